// [core/apc_pkg.sv]
// Shared constants and carrier types for the priority result and compare block
package apc_pkg;
  localparam int          RES_W      = 10;
  localparam int          RES_LSB    = 6;
  localparam int          SEL_W      = 4;
  localparam int          OVR_BIT    = 1;
  localparam int          STORED_BIT = 0;
  localparam int          CTL_EN_BIT = 0;
  localparam int          CTL_DIR_BIT = 1;
  localparam int          CTL_SEL_LSB = 4;
  localparam int          INT_W      = 4;
  localparam int          INT_STORED = 0;
  localparam int          INT_OVR    = 1;
  localparam int          INT_MON0   = 2;
  localparam int          INT_MON1   = 3;
  localparam int          ADDR_W     = 8;
  localparam logic [7:0]  OFS_PRI    = 8'h00;
  localparam logic [7:0]  OFS_THR0   = 8'h04;
  localparam logic [7:0]  OFS_THR1   = 8'h08;
  localparam logic [7:0]  OFS_CTL0   = 8'h0C;
  localparam logic [7:0]  OFS_CTL1   = 8'h10;
  localparam logic [7:0]  OFS_STAT   = 8'h14;
  localparam logic [7:0]  OFS_MASK   = 8'h18;
  localparam logic [3:0]  PRI_SEL    = 4'hF;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  localparam logic [9:0]  RST_RES    = 10'h000;

  typedef struct packed {
    logic             wr;
    logic [SEL_W-1:0] sel;
    logic [RES_W-1:0] data;
  } apc_res_s;

  typedef struct packed {
    logic             en;
    logic             larger;
    logic [SEL_W-1:0] sel;
  } apc_mon_ctl_s;

  localparam apc_mon_ctl_s RST_CTL = '{en: 1'b0, larger: 1'b0, sel: 4'h0};
endpackage

// [core/apc_monitor.sv]
// One result-monitor channel: compares stored results with a threshold
`timescale 1ns/1ps
module apc_monitor #(
  parameter int SRC_N = 2
) (
  input  wire logic                             clk,
  input  wire logic                             rst,
  input  wire apc_pkg::apc_res_s [SRC_N-1:0]    ev,
  input  wire apc_pkg::apc_mon_ctl_s            ctl,
  input  wire logic [apc_pkg::RES_W-1:0]        thr,
  output logic                                  hit
);
  logic hit_r;
  logic hit_nxt;

  always_comb begin
    hit_nxt = 1'b0;
    for (int i = 0; i < SRC_N; i++) begin
      // Compare on every store into the selected result while ctl.en is set
      if (ctl.en && ev[i].wr && ev[i].sel == ctl.sel) begin
        if (ctl.larger ? (ev[i].data > thr) : (ev[i].data < thr)) begin
          hit_nxt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= hit_nxt;
    end
  end

  assign hit = hit_r;

  chk_hit_larger: assert property (@(posedge clk) disable iff (rst)
    (ctl.en && ctl.larger && ev[0].wr && ev[0].sel == ctl.sel &&
     ev[0].data > thr) |=> hit)
    else $error("monitor missed a larger result");
  chk_hit_enabled: assert property (@(posedge clk) disable iff (rst)
    hit |-> $past(ctl.en) && $past(ev[0].wr || ev[SRC_N-1].wr))
    else $error("monitor fired without enabled store");
endmodule

// [core/apc_irq.sv]
// Sticky event status with write-one-to-clear and masked interrupt level
`timescale 1ns/1ps
module apc_irq #(
  parameter int N = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [N-1:0] set,
  input  wire logic [N-1:0] clr,
  input  wire logic [N-1:0] mask,
  output logic      [N-1:0] status,
  output logic              irq
);
  logic [N-1:0] status_r;
  logic [N-1:0] status_nxt;

  // A set in the clearing cycle wins so no event is lost
  always_comb begin
    status_nxt = set | (status_r & ~clr);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign status = status_r;
  assign irq    = |(status_r & mask);

  chk_set_wins: assert property (@(posedge clk) disable iff (rst)
    (set != '0) |=> ((status_r & $past(set)) == $past(set)))
    else $error("status event lost");
  chk_w1c_clear: assert property (@(posedge clk) disable iff (rst)
    (clr != '0) |=> ((status_r & $past(clr & ~set)) == '0))
    else $error("status bit not cleared");
endmodule

// [core/apc_top.sv]
// Priority result, compare thresholds and monitors behind an AXI4-Lite slave
`timescale 1ns/1ps
module apc_top (
  input  wire logic                       SYS_CLK,
  input  wire logic                       RST,
  input  wire logic [apc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                       S_AXI_AWVALID,
  output logic                            S_AXI_AWREADY,
  input  wire logic [31:0]                S_AXI_WDATA,
  input  wire logic [3:0]                 S_AXI_WSTRB,
  input  wire logic                       S_AXI_WVALID,
  output logic                            S_AXI_WREADY,
  output logic [1:0]                      S_AXI_BRESP,
  output logic                            S_AXI_BVALID,
  input  wire logic                       S_AXI_BREADY,
  input  wire logic [apc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic                       S_AXI_ARVALID,
  output logic                            S_AXI_ARREADY,
  output logic [31:0]                     S_AXI_RDATA,
  output logic [1:0]                      S_AXI_RRESP,
  output logic                            S_AXI_RVALID,
  input  wire logic                       S_AXI_RREADY,
  input  wire logic                       PRI_WR,
  input  wire logic [apc_pkg::RES_W-1:0]  PRI_DATA,
  input  wire logic                       RES_WR,
  input  wire logic [apc_pkg::SEL_W-1:0]  RES_SEL,
  input  wire logic [apc_pkg::RES_W-1:0]  RES_DATA,
  output logic                            MON_ZERO_INT,
  output logic                            MON_ONE_INT,
  output logic                            IRQ
);
  localparam int RMSB = apc_pkg::RES_LSB + apc_pkg::RES_W - 1;

  logic                                   aw_h_r, aw_h_nxt;
  logic [apc_pkg::ADDR_W-1:0]             awaddr_r, awaddr_nxt;
  logic                                   w_h_r, w_h_nxt;
  logic [31:0]                            wdata_r, wdata_nxt;
  logic [3:0]                             wstrb_r, wstrb_nxt;
  logic                                   bvalid_r, bvalid_nxt;
  logic [1:0]                             bresp_r, bresp_nxt;
  logic                                   rvalid_r, rvalid_nxt;
  logic [31:0]                            rdata_r, rdata_nxt;
  logic [1:0]                             rresp_r, rresp_nxt;
  logic [apc_pkg::RES_W-1:0]              pri_r, pri_nxt;
  logic                                   stored_r, stored_nxt;
  logic                                   ovr_r, ovr_nxt;
  logic [apc_pkg::RES_W-1:0]              thr0_r, thr0_nxt;
  logic [apc_pkg::RES_W-1:0]              thr1_r, thr1_nxt;
  apc_pkg::apc_mon_ctl_s                  ctl0_r, ctl0_nxt;
  apc_pkg::apc_mon_ctl_s                  ctl1_r, ctl1_nxt;
  logic [apc_pkg::INT_W-1:0]              mask_r, mask_nxt;
  logic [apc_pkg::INT_W-1:0]              int_set, int_clr, int_stat;
  logic                                   do_wr, ar_hs, rd_pri, ovr_set;
  logic                                   hit0, hit1;
  logic [31:0]                            wword;
  logic [31:0]                            thr0_m, thr1_m;
  apc_pkg::apc_res_s [1:0]                ev;

  function automatic logic hit_ofs(input logic [apc_pkg::ADDR_W-1:0] a,
                                   input logic [7:0] ofs);
    hit_ofs = (a[apc_pkg::ADDR_W-1:2] == ofs[apc_pkg::ADDR_W-1:2]);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    merge = m;
  endfunction

  function automatic logic [31:0] ctl_word(input apc_pkg::apc_mon_ctl_s c);
    logic [31:0] w;
    w = apc_pkg::RST_WORD;
    w[apc_pkg::CTL_EN_BIT] = c.en;
    w[apc_pkg::CTL_DIR_BIT] = c.larger;
    w[apc_pkg::CTL_SEL_LSB +: apc_pkg::SEL_W] = c.sel;
    ctl_word = w;
  endfunction

  function automatic apc_pkg::apc_mon_ctl_s ctl_of(input logic [31:0] w);
    apc_pkg::apc_mon_ctl_s c;
    c.en = w[apc_pkg::CTL_EN_BIT];
    c.larger = w[apc_pkg::CTL_DIR_BIT];
    c.sel = w[apc_pkg::CTL_SEL_LSB +: apc_pkg::SEL_W];
    ctl_of = c;
  endfunction

  function automatic logic [31:0] res_word(input logic [9:0] v);
    logic [31:0] w;
    w = apc_pkg::RST_WORD;
    w[RMSB:apc_pkg::RES_LSB] = v;
    res_word = w;
  endfunction

  assign do_wr   = aw_h_r && w_h_r && !bvalid_r;
  assign ar_hs   = S_AXI_ARVALID && S_AXI_ARREADY;
  assign rd_pri  = ar_hs && hit_ofs(S_AXI_ARADDR, apc_pkg::OFS_PRI);
  assign ovr_set = PRI_WR && stored_r;
  assign wword   = wdata_r;
  assign thr0_m  = merge(res_word(thr0_r), wword, wstrb_r);
  assign thr1_m  = merge(res_word(thr1_r), wword, wstrb_r);

  // Bus channel state
  always_comb begin
    aw_h_nxt   = aw_h_r;
    awaddr_nxt = awaddr_r;
    w_h_nxt    = w_h_r;
    wdata_nxt  = wdata_r;
    wstrb_nxt  = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_h_nxt   = 1'b1;
      awaddr_nxt = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_h_nxt   = 1'b1;
      wdata_nxt = S_AXI_WDATA;
      wstrb_nxt = S_AXI_WSTRB;
    end
    if (do_wr) begin
      aw_h_nxt   = 1'b0;
      w_h_nxt    = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = (hit_ofs(awaddr_r, apc_pkg::OFS_PRI)  ||
                    hit_ofs(awaddr_r, apc_pkg::OFS_THR0) ||
                    hit_ofs(awaddr_r, apc_pkg::OFS_THR1) ||
                    hit_ofs(awaddr_r, apc_pkg::OFS_CTL0) ||
                    hit_ofs(awaddr_r, apc_pkg::OFS_CTL1) ||
                    hit_ofs(awaddr_r, apc_pkg::OFS_STAT) ||
                    hit_ofs(awaddr_r, apc_pkg::OFS_MASK)) ?
                   apc_pkg::RESP_OKAY : apc_pkg::RESP_SLVERR;
    end else if (bvalid_r && S_AXI_BREADY) begin
      bvalid_nxt = 1'b0;
    end
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (ar_hs) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = apc_pkg::RESP_OKAY;
      // Unused bits assemble as zero
      if (hit_ofs(S_AXI_ARADDR, apc_pkg::OFS_PRI)) begin
        rdata_nxt = res_word(pri_r);
        rdata_nxt[apc_pkg::OVR_BIT] = ovr_r;
        rdata_nxt[apc_pkg::STORED_BIT] = stored_r;
      end else if (hit_ofs(S_AXI_ARADDR, apc_pkg::OFS_THR0)) begin
        rdata_nxt = res_word(thr0_r);
      end else if (hit_ofs(S_AXI_ARADDR, apc_pkg::OFS_THR1)) begin
        rdata_nxt = res_word(thr1_r);
      end else if (hit_ofs(S_AXI_ARADDR, apc_pkg::OFS_CTL0)) begin
        rdata_nxt = ctl_word(ctl0_r);
      end else if (hit_ofs(S_AXI_ARADDR, apc_pkg::OFS_CTL1)) begin
        rdata_nxt = ctl_word(ctl1_r);
      end else if (hit_ofs(S_AXI_ARADDR, apc_pkg::OFS_STAT)) begin
        rdata_nxt = {28'h0000000, int_stat};
      end else if (hit_ofs(S_AXI_ARADDR, apc_pkg::OFS_MASK)) begin
        rdata_nxt = {28'h0000000, mask_r};
      end else begin
        rdata_nxt = apc_pkg::RST_WORD;
        rresp_nxt = apc_pkg::RESP_SLVERR;
      end
    end else if (rvalid_r && S_AXI_RREADY) begin
      rvalid_nxt = 1'b0;
    end
  end

  // Result and configuration state
  always_comb begin
    pri_nxt    = PRI_WR ? PRI_DATA : pri_r;
    // New outcome wins over a read in the same cycle
    stored_nxt = PRI_WR || (stored_r && !rd_pri);
    ovr_nxt    = ovr_set || (ovr_r && !rd_pri);
    thr0_nxt   = thr0_r;
    thr1_nxt   = thr1_r;
    ctl0_nxt   = ctl0_r;
    ctl1_nxt   = ctl1_r;
    mask_nxt   = mask_r;
    int_clr    = '0;
    if (do_wr) begin
      // Thresholds locked while their channel runs, so a compare
      // never sees a half-written value
      if (hit_ofs(awaddr_r, apc_pkg::OFS_THR0) && !ctl0_r.en) begin
        thr0_nxt = thr0_m[RMSB:apc_pkg::RES_LSB];
      end
      if (hit_ofs(awaddr_r, apc_pkg::OFS_THR1) && !ctl1_r.en) begin
        thr1_nxt = thr1_m[RMSB:apc_pkg::RES_LSB];
      end
      if (hit_ofs(awaddr_r, apc_pkg::OFS_CTL0) && wstrb_r[0]) begin
        ctl0_nxt = ctl_of(wword);
      end
      if (hit_ofs(awaddr_r, apc_pkg::OFS_CTL1) && wstrb_r[0]) begin
        ctl1_nxt = ctl_of(wword);
      end
      if (hit_ofs(awaddr_r, apc_pkg::OFS_STAT) && wstrb_r[0]) begin
        int_clr = wword[apc_pkg::INT_W-1:0];
      end
      if (hit_ofs(awaddr_r, apc_pkg::OFS_MASK) && wstrb_r[0]) begin
        mask_nxt = wword[apc_pkg::INT_W-1:0];
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      aw_h_r   <= 1'b0;
      awaddr_r <= '0;
      w_h_r    <= 1'b0;
      wdata_r  <= apc_pkg::RST_WORD;
      wstrb_r  <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= apc_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r  <= apc_pkg::RST_WORD;
      rresp_r  <= apc_pkg::RESP_OKAY;
      pri_r    <= apc_pkg::RST_RES;
      stored_r <= 1'b0;
      ovr_r    <= 1'b0;
      thr0_r   <= apc_pkg::RST_RES;
      thr1_r   <= apc_pkg::RST_RES;
      ctl0_r   <= apc_pkg::RST_CTL;
      ctl1_r   <= apc_pkg::RST_CTL;
      mask_r   <= '0;
    end else begin
      aw_h_r   <= aw_h_nxt;
      awaddr_r <= awaddr_nxt;
      w_h_r    <= w_h_nxt;
      wdata_r  <= wdata_nxt;
      wstrb_r  <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
      pri_r    <= pri_nxt;
      stored_r <= stored_nxt;
      ovr_r    <= ovr_nxt;
      thr0_r   <= thr0_nxt;
      thr1_r   <= thr1_nxt;
      ctl0_r   <= ctl0_nxt;
      ctl1_r   <= ctl1_nxt;
      mask_r   <= mask_nxt;
    end
  end

  assign S_AXI_AWREADY = !aw_h_r && !bvalid_r;
  assign S_AXI_WREADY  = !w_h_r && !bvalid_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_BRESP   = bresp_r;
  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_RVALID  = rvalid_r;
  assign S_AXI_RDATA   = rdata_r;
  assign S_AXI_RRESP   = rresp_r;

  assign ev[0] = '{wr: RES_WR, sel: RES_SEL, data: RES_DATA};
  assign ev[1] = '{wr: PRI_WR, sel: apc_pkg::PRI_SEL, data: PRI_DATA};

  apc_monitor #(.SRC_N(2)) u_mon0 (
    .clk (SYS_CLK),
    .rst (RST),
    .ev  (ev),
    .ctl (ctl0_r),
    .thr (thr0_r),
    .hit (hit0)
  );

  apc_monitor #(.SRC_N(2)) u_mon1 (
    .clk (SYS_CLK),
    .rst (RST),
    .ev  (ev),
    .ctl (ctl1_r),
    .thr (thr1_r),
    .hit (hit1)
  );

  assign MON_ZERO_INT = hit0;
  assign MON_ONE_INT  = hit1;
  assign int_set = {hit1, hit0, ovr_set, PRI_WR};

  apc_irq #(.N(apc_pkg::INT_W)) u_irq (
    .clk    (SYS_CLK),
    .rst    (RST),
    .set    (int_set),
    .clr    (int_clr),
    .mask   (mask_r),
    .status (int_stat),
    .irq    (IRQ)
  );

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence s_wr_ready;
    aw_h_r && w_h_r && !bvalid_r;
  endsequence
  sequence s_resp_held;
    bvalid_r && !S_AXI_BREADY;
  endsequence

  chk_bresp_follow: assert property (s_wr_ready |=> bvalid_r && !aw_h_r)
    else $error("write response did not follow");
  chk_bresp_hold: assert property (s_resp_held |=> bvalid_r &&
                                   $stable(bresp_r))
    else $error("write response dropped early");
  chk_pri_store: assert property (PRI_WR |=> stored_r &&
                                  pri_r == $past(PRI_DATA))
    else $error("priority result not stored");
  chk_pri_rdclr: assert property (rd_pri && !PRI_WR |=>
                                  !stored_r && !ovr_r)
    else $error("read did not clear flags");
  chk_ovr_set: assert property (PRI_WR && stored_r |=> ovr_r)
    else $error("overrun not flagged");
  chk_ovr_cause: assert property ($rose(ovr_r) |->
                                  $past(PRI_WR && stored_r))
    else $error("overrun without replace");
  chk_thr_lock: assert property (do_wr && ctl0_r.en |=>
                                 $stable(thr0_r))
    else $error("threshold zero changed while enabled");
  chk_rd_zero: assert property (rd_pri |=>
                                S_AXI_RDATA[31:16] == 16'h0000 &&
                                S_AXI_RDATA[5:2] == 4'h0)
    else $error("unused result bits not zero");
endmodule

// [verif/testbench.sv]
// Self-checking testbench for the priority result and compare block
`timescale 1ns/1ps
module testbench;
  logic                       sys_clk;
  logic                       rst;
  logic [apc_pkg::ADDR_W-1:0] aw_addr;
  logic                       aw_valid;
  logic                       aw_ready;
  logic [31:0]                w_data;
  logic [3:0]                 w_strb;
  logic                       w_valid;
  logic                       w_ready;
  logic [1:0]                 b_resp;
  logic                       b_valid;
  logic                       b_ready;
  logic [apc_pkg::ADDR_W-1:0] ar_addr;
  logic                       ar_valid;
  logic                       ar_ready;
  logic [31:0]                r_data;
  logic [1:0]                 r_resp;
  logic                       r_valid;
  logic                       r_ready;
  logic                       pri_wr;
  logic [apc_pkg::RES_W-1:0]  pri_data;
  logic                       res_wr;
  logic [apc_pkg::SEL_W-1:0]  res_sel;
  logic [apc_pkg::RES_W-1:0]  res_data;
  logic                       mon_zero_int;
  logic                       mon_one_int;
  logic                       irq;
  int                         num_errors;
  int                         checks_done;
  logic [31:0]                rd;
  logic [1:0]                 rsp;
  logic [3:0]                 wr_strb;

  apc_top i_apc_top (
    .SYS_CLK(sys_clk), .RST(rst),
    .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid),
    .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb),
    .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp),
    .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready),
    .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid),
    .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp),
    .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready),
    .PRI_WR(pri_wr), .PRI_DATA(pri_data), .RES_WR(res_wr),
    .RES_SEL(res_sel), .RES_DATA(res_data),
    .MON_ZERO_INT(mon_zero_int), .MON_ONE_INT(mon_one_int), .IRQ(irq)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic test_done;
    if (num_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_cnt(input string what, input int exp, input int got);
    checks_done++;
    if (got != exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // Valid and payload held until the ready edge; bready held until bvalid
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] resp);
    aw_addr  <= a;
    w_data   <= d;
    w_strb   <= wr_strb;
    aw_valid <= 1'b1;
    w_valid  <= 1'b1;
    b_ready  <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (aw_valid && aw_ready) aw_valid <= 1'b0;
      if (w_valid && w_ready) w_valid <= 1'b0;
      if (b_valid === 1'b1) break;
    end
    resp = b_resp;
    b_ready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    ar_addr  <= a;
    ar_valid <= 1'b1;
    r_ready  <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (ar_valid && ar_ready) ar_valid <= 1'b0;
      if (r_valid === 1'b1) break;
    end
    d = r_data;
    resp = r_resp;
    r_ready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Hit pulses are counted over a short window after the store edge
  task automatic count_hits(input int e0, input int e1);
    int n0;
    int n1;
    n0 = 0;
    n1 = 0;
    repeat (4) begin
      @(posedge sys_clk);
      if (mon_zero_int === 1'b1) n0++;
      if (mon_one_int === 1'b1) n1++;
    end
    chk_cnt("mon_zero_hits", e0, n0);
    chk_cnt("mon_one_hits", e1, n1);
  endtask

  task automatic ev_pri(input logic [9:0] d, input int e0, input int e1);
    pri_wr   <= 1'b1;
    pri_data <= d;
    @(posedge sys_clk);
    pri_wr <= 1'b0;
    count_hits(e0, e1);
  endtask

  task automatic ev_res(input logic [3:0] s, input logic [9:0] d,
                        input int e0, input int e1);
    res_wr   <= 1'b1;
    res_sel  <= s;
    res_data <= d;
    @(posedge sys_clk);
    res_wr <= 1'b0;
    count_hits(e0, e1);
  endtask

  function automatic logic [31:0] pri_word(input logic [9:0] d,
                                           input logic o, input logic s);
    return {16'h0000, d, 4'h0, o, s};
  endfunction

  task automatic t_reset;
    axi_read(apc_pkg::OFS_PRI, rd, rsp);
    chk_word("pri_reset", 32'h0000_0000, rd);
    axi_read(apc_pkg::OFS_THR0, rd, rsp);
    chk_word("thr0_reset", 32'h0000_0000, rd);
    axi_read(apc_pkg::OFS_THR1, rd, rsp);
    chk_word("thr1_reset", 32'h0000_0000, rd);
    axi_read(8'h1C, rd, rsp);
    chk_word("unmapped_rresp", {30'h0, apc_pkg::RESP_SLVERR}, {30'h0, rsp});
  endtask

  task automatic t_pri;
    ev_pri(10'h2AB, 0, 0);
    axi_read(apc_pkg::OFS_PRI, rd, rsp);
    chk_word("pri_first", pri_word(10'h2AB, 1'b0, 1'b1), rd);
    chk_word("pri_ok", {30'h0, apc_pkg::RESP_OKAY}, {30'h0, rsp});
    axi_read(apc_pkg::OFS_PRI, rd, rsp);
    chk_word("pri_reread", pri_word(10'h2AB, 1'b0, 1'b0), rd);
  endtask

  task automatic t_ovr;
    ev_pri(10'h155, 0, 0);
    ev_pri(10'h3FF, 0, 0);
    axi_read(apc_pkg::OFS_PRI, rd, rsp);
    chk_word("pri_overrun", pri_word(10'h3FF, 1'b1, 1'b1), rd);
    axi_read(apc_pkg::OFS_PRI, rd, rsp);
    chk_word("pri_ovr_clear", pri_word(10'h3FF, 1'b0, 1'b0), rd);
  endtask

  task automatic t_thr;
    axi_write(apc_pkg::OFS_THR0, 32'hFFFF_FFFF, rsp);
    chk_word("thr0_ok", {30'h0, apc_pkg::RESP_OKAY}, {30'h0, rsp});
    axi_read(apc_pkg::OFS_THR0, rd, rsp);
    chk_word("thr0_bits", 32'h0000_FFC0, rd);
    axi_write(apc_pkg::OFS_THR1, 32'h1234_5678, rsp);
    axi_read(apc_pkg::OFS_THR1, rd, rsp);
    chk_word("thr1_bits", 32'h0000_5640, rd);
    // Only byte zero enabled: the two low threshold bits change alone
    wr_strb = 4'h1;
    axi_write(apc_pkg::OFS_THR1, 32'h0000_FFFF, rsp);
    wr_strb = 4'hF;
    axi_read(apc_pkg::OFS_THR1, rd, rsp);
    chk_word("thr1_strobe", 32'h0000_56C0, rd);
    axi_write(apc_pkg::OFS_PRI, 32'hFFFF_FFFF, rsp);
    axi_read(apc_pkg::OFS_PRI, rd, rsp);
    chk_word("pri_readonly", pri_word(10'h3FF, 1'b0, 1'b0), rd);
    axi_write(8'h1C, 32'h0000_0001, rsp);
    chk_word("unmapped_bresp", {30'h0, apc_pkg::RESP_SLVERR}, {30'h0, rsp});
  endtask

  task automatic t_mon0;
    axi_write(apc_pkg::OFS_STAT, 32'h0000_000F, rsp);
    axi_write(apc_pkg::OFS_MASK, 32'h0000_0004, rsp);
    axi_write(apc_pkg::OFS_THR0, 32'h0000_4000, rsp);
    axi_write(apc_pkg::OFS_CTL0, 32'h0000_00F3, rsp);
    axi_read(apc_pkg::OFS_CTL0, rd, rsp);
    chk_word("ctl0_bits", 32'h0000_00F3, rd);
    axi_read(apc_pkg::OFS_MASK, rd, rsp);
    chk_word("mask_bits", 32'h0000_0004, rd);
    // Enabled channel: the device guards against a threshold change
    axi_write(apc_pkg::OFS_THR0, 32'h0000_0000, rsp);
    axi_read(apc_pkg::OFS_THR0, rd, rsp);
    chk_word("thr0_guard", 32'h0000_4000, rd);
    ev_pri(10'h100, 0, 0);
    ev_pri(10'h101, 1, 0);
    axi_read(apc_pkg::OFS_STAT, rd, rsp);
    chk_word("status_events", 32'h0000_0007, rd);
    chk_word("irq_raised", 32'h1, {31'h0, irq});
    axi_write(apc_pkg::OFS_STAT, 32'h0000_0004, rsp);
    chk_word("irq_cleared", 32'h0, {31'h0, irq});
    axi_write(apc_pkg::OFS_CTL0, 32'h0000_00F1, rsp);
    ev_pri(10'h0FF, 1, 0);
    axi_write(apc_pkg::OFS_CTL0, 32'h0000_00F0, rsp);
    ev_pri(10'h000, 0, 0);
  endtask

  task automatic t_mon1;
    axi_write(apc_pkg::OFS_THR1, 32'h0000_2000, rsp);
    axi_write(apc_pkg::OFS_CTL1, 32'h0000_0031, rsp);
    axi_write(apc_pkg::OFS_THR1, 32'h0000_FFC0, rsp);
    axi_read(apc_pkg::OFS_THR1, rd, rsp);
    chk_word("thr1_guard", 32'h0000_2000, rd);
    ev_res(4'h3, 10'h07F, 0, 1);
    ev_res(4'h3, 10'h080, 0, 0);
    ev_res(4'h5, 10'h000, 0, 0);
    ev_pri(10'h000, 0, 0);
    axi_write(apc_pkg::OFS_MASK, 32'h0000_0008, rsp);
    chk_word("irq_mon1", 32'h1, {31'h0, irq});
    axi_write(apc_pkg::OFS_MASK, 32'h0000_0000, rsp);
    chk_word("irq_masked", 32'h0, {31'h0, irq});
  endtask

  initial begin
    num_errors  = 0;
    checks_done = 0;
    rst      = 1'b1;
    aw_addr  = '0;
    aw_valid = 1'b0;
    w_data   = '0;
    w_strb   = 4'h0;
    wr_strb  = 4'hF;
    w_valid  = 1'b0;
    b_ready  = 1'b0;
    ar_addr  = '0;
    ar_valid = 1'b0;
    r_ready  = 1'b0;
    pri_wr   = 1'b0;
    pri_data = '0;
    res_wr   = 1'b0;
    res_sel  = '0;
    res_data = '0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_pri();
    t_ovr();
    t_thr();
    t_mon0();
    t_mon1();
    test_done();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    test_done();
  end
endmodule
